// [verilog/io_ports_with_alt_functions.sv]
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "io_ports_regs.svh"

// How it works
// - Configured peripheral takes pin over, overriding data and direction bits.
// - Peripheral-driven pins forced to output, push-pull or open-drain as needed.
// - Pins feeding peripherals as inputs still read back live level.
// - Port A resets input; pins 1,2 open-drain I2C, others pulled up.
// - Port B resets floating input; pin n on mux when channel equals n.
// - Port B pins 4-7 are external interrupt inputs five to eight.
// - Port A 4-7 interrupts one-four; 4,5 capture; 6,7 compare outputs.
// - Port C pulled up; 0 serial in, 1 serial out, 2 USB enable.
// - Data register writes always update the latch, even on inputs.
// - Data reads give latch for outputs, live pin for inputs.
// - Direction bit zero input, one output; A and B reset zero.
// - Port C upper five bits read one; low three bits reset zero.
// - Misc register at its own address, resets F0h, upper bits set.
// - Misc bit 3 set by software, cleared only by reset; disables detector.
// - Misc bit 2 set by software, cleared only by reset; selects 12 MHz.
// - Plain output pins drive the data latch value; A1,A2 only drive low and release on a one.
// - Output pins never raise external interrupts.
// - Lines 1,2,5,6 rising; 3,4,7,8 falling; vector bit 0 ORs lines 1-4, bit 1 ORs 5-8.
module io_ports_with_alt_functions #(
  parameter int PORT_C_PINS = `PORT_C_WIDTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic [3:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_analog_select,
  input wire logic [PORT_C_PINS-1:0] port_c_in,
  output logic [PORT_C_PINS-1:0] port_c_out,
  output logic [PORT_C_PINS-1:0] port_c_oe,
  output logic [PORT_C_PINS-1:0] port_c_pullup,
  input wire logic cpu_clock_level,
  input wire logic i2c_enable,
  input wire logic i2c_sda_out,
  input wire logic i2c_scl_out,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  input wire logic timer_clock_ctl_hi,
  input wire logic timer_clock_ctl_lo,
  output logic timer_external_clock,
  output logic timer_capture_in_1,
  output logic timer_capture_in_2,
  input wire logic timer_compare_out_1,
  input wire logic timer_compare_out_2,
  input wire logic compare_out_1_enable,
  input wire logic compare_out_2_enable,
  input wire logic serial_enable,
  input wire logic serial_transmit_out,
  output logic serial_receive_in,
  input wire logic usb_transmitting,
  input wire logic [2:0] converter_channel_select,
  input wire logic converter_enable,
  output logic [3:0] ext_irq_vector,
  output logic low_voltage_detect_disable,
  output logic osc_select_12mhz
);

  io_ports_pkg::byte_type port_a_data;
  io_ports_pkg::byte_type port_a_direction;
  io_ports_pkg::byte_type port_b_data;
  io_ports_pkg::byte_type port_b_direction;
  logic [PORT_C_PINS-1:0] port_c_data;
  logic [PORT_C_PINS-1:0] port_c_direction;
  io_ports_pkg::byte_type ext_irq_enable_reg;
  logic clock_out_enable;
  logic usb_tx_enable_out;
  logic [7:0] a_meta, a_sync, a_prev;
  logic [7:0] b_meta, b_sync, b_prev;
  logic [PORT_C_PINS-1:0] c_meta, c_sync;
  io_ports_pkg::sync_state_type sync_state;
  logic [7:0] a_alt_oe, a_alt_val;
  logic [PORT_C_PINS-1:0] c_alt_oe, c_alt_val;
  logic [7:0] ext_irq_line;
  logic [7:0] next_read_data;
  logic [7:0] c_read_mix;
  // Whole-register reset image; field reset values are cut from it
  localparam logic [7:0] MISC_RESET = `MISC_RESET_VALUE;

  // Reads mix latch and pin, bit by bit
  function automatic logic [7:0] mix_read(input logic [7:0] latch, input logic [7:0] pins,
                                          input logic [7:0] dir);
    mix_read = (latch & dir) | (pins & ~dir);
  endfunction

  function automatic logic hit(input logic [3:0] off);
    hit = write_strobe && (address == off);
  endfunction

  // Two-flop synchroniser; first stage read only by second
  always_ff @(posedge clock) begin
    if (reset) begin
      a_meta <= 8'h00;
      a_sync <= 8'h00;
      b_meta <= 8'h00;
      b_sync <= 8'h00;
      c_meta <= '0;
      c_sync <= '0;
    end else if (clock_enable) begin
      a_meta <= port_a_in;
      a_sync <= a_meta;
      b_meta <= port_b_in;
      b_sync <= b_meta;
      c_meta <= port_c_in;
      c_sync <= c_meta;
    end
  end

  // Edge history is invalid until the pipe has filled
  // Third step needed: prev must hold a real level, else reset zeros fake a rising edge
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_state <= io_ports_pkg::SYNC_EMPTY;
      a_prev <= 8'h00;
      b_prev <= 8'h00;
    end else if (clock_enable) begin
      a_prev <= a_sync;
      b_prev <= b_sync;
      case (sync_state)
        io_ports_pkg::SYNC_EMPTY: sync_state <= io_ports_pkg::SYNC_FIRST;
        io_ports_pkg::SYNC_FIRST: sync_state <= io_ports_pkg::SYNC_SECOND;
        io_ports_pkg::SYNC_SECOND: sync_state <= io_ports_pkg::SYNC_READY;
        io_ports_pkg::SYNC_READY: sync_state <= io_ports_pkg::SYNC_READY;
        default: sync_state <= io_ports_pkg::SYNC_EMPTY;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      port_a_data <= `PORT_RESET_VALUE;
      port_b_data <= `PORT_RESET_VALUE;
      port_c_data <= '0;
    end else if (clock_enable) begin
      if (hit(`PORT_A_DATA_OFFSET)) port_a_data <= write_data;
      if (hit(`PORT_B_DATA_OFFSET)) port_b_data <= write_data;
      if (hit(`PORT_C_DATA_OFFSET)) port_c_data <= write_data[PORT_C_PINS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      port_a_direction <= `PORT_RESET_VALUE;
      port_b_direction <= `PORT_RESET_VALUE;
      port_c_direction <= '0;
    end else if (clock_enable) begin
      if (hit(`PORT_A_DIRECTION_OFFSET)) port_a_direction <= write_data;
      if (hit(`PORT_B_DIRECTION_OFFSET)) port_b_direction <= write_data;
      if (hit(`PORT_C_DIRECTION_OFFSET)) port_c_direction <= write_data[PORT_C_PINS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ext_irq_enable_reg <= 8'h00;
    end else if (clock_enable && hit(`EXT_IRQ_ENABLE_OFFSET)) begin
      ext_irq_enable_reg <= write_data;
    end
  end

  // Detector and oscillator bits are sticky: software cannot clear them
  always_ff @(posedge clock) begin
    if (reset) begin
      low_voltage_detect_disable <= MISC_RESET[`MISC_LVD_DISABLE_BIT];
      osc_select_12mhz <= MISC_RESET[`MISC_OSC_SELECT_BIT];
      usb_tx_enable_out <= MISC_RESET[`MISC_USB_OE_BIT];
      clock_out_enable <= MISC_RESET[`MISC_CLOCK_OUT_BIT];
    end else if (clock_enable && hit(`MISC_CONTROL_OFFSET)) begin
      if (write_data[`MISC_LVD_DISABLE_BIT]) low_voltage_detect_disable <= 1'b1;
      if (write_data[`MISC_OSC_SELECT_BIT]) osc_select_12mhz <= 1'b1;
      usb_tx_enable_out <= write_data[`MISC_USB_OE_BIT];
      clock_out_enable <= write_data[`MISC_CLOCK_OUT_BIT];
    end
  end

  // Alternate functions beat data and direction bits
  always_comb begin
    a_alt_oe = 8'h00;
    a_alt_val = 8'h00;
    a_alt_oe[0] = clock_out_enable;
    a_alt_val[0] = cpu_clock_level;
    a_alt_oe[1] = i2c_enable & ~i2c_sda_out;
    a_alt_oe[2] = i2c_enable & ~i2c_scl_out;
    a_alt_oe[6] = compare_out_1_enable;
    a_alt_val[6] = timer_compare_out_1;
    a_alt_oe[7] = compare_out_2_enable;
    a_alt_val[7] = timer_compare_out_2;
    c_alt_oe = '0;
    c_alt_val = '0;
    c_alt_oe[1] = serial_enable;
    c_alt_val[1] = serial_transmit_out;
    c_alt_oe[2] = usb_tx_enable_out;
    c_alt_val[2] = usb_transmitting;
  end

  // Open-drain pins 1,2: drive only low, never high
  always_comb begin
    port_a_oe = a_alt_oe | (port_a_direction & ~({6'h00, i2c_enable, i2c_enable} << 1));
    port_a_out = (a_alt_oe & a_alt_val) | (~a_alt_oe & port_a_data);
    port_a_out[2:1] = 2'b00;
    port_a_oe[2:1] = i2c_enable ? a_alt_oe[2:1] : port_a_direction[2:1] & ~port_a_data[2:1];
    port_a_pullup = ~port_a_oe & 8'hf9;
    port_b_oe = port_b_direction;
    port_b_out = port_b_data;
    port_c_oe = c_alt_oe | port_c_direction;
    port_c_out = (c_alt_oe & c_alt_val) | (~c_alt_oe & port_c_data);
    port_c_pullup = ~port_c_oe;
  end

  always_comb begin
    port_b_analog_select = 8'h00;
    if (converter_enable) port_b_analog_select[converter_channel_select] = 1'b1;
  end

  // Peripheral inputs see live synchronised levels
  assign i2c_sda_in = a_sync[1];
  assign i2c_scl_in = a_sync[2];
  assign timer_capture_in_1 = a_sync[4];
  assign timer_capture_in_2 = a_sync[5];
  assign timer_external_clock = timer_clock_ctl_hi & timer_clock_ctl_lo & a_sync[3];
  assign serial_receive_in = c_sync[0];

  // Lines 1..8 on A4..A7 then B4..B7; output pins masked
  always_comb begin
    ext_irq_line = 8'h00;
    if (sync_state == io_ports_pkg::SYNC_READY) begin
      ext_irq_line[0] = a_sync[4] & ~a_prev[4] & ~port_a_oe[4];
      ext_irq_line[1] = a_sync[5] & ~a_prev[5] & ~port_a_oe[5];
      ext_irq_line[2] = ~a_sync[6] & a_prev[6] & ~port_a_oe[6];
      ext_irq_line[3] = ~a_sync[7] & a_prev[7] & ~port_a_oe[7];
      ext_irq_line[4] = b_sync[4] & ~b_prev[4] & ~port_b_oe[4];
      ext_irq_line[5] = b_sync[5] & ~b_prev[5] & ~port_b_oe[5];
      ext_irq_line[6] = ~b_sync[6] & b_prev[6] & ~port_b_oe[6];
      ext_irq_line[7] = ~b_sync[7] & b_prev[7] & ~port_b_oe[7];
    end
    ext_irq_line = ext_irq_line & ext_irq_enable_reg;
  end

  // Vector split across port A and port B groups
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_irq_vector <= 4'h0;
    end else if (clock_enable) begin
      ext_irq_vector <= {2'b00, |ext_irq_line[7:4], |ext_irq_line[3:0]};
    end
  end

  // Zero-extended so the byte-wide helper serves the narrow port
  assign c_read_mix = mix_read(8'(port_c_data), 8'(c_sync), 8'(port_c_oe));

  always_comb begin
    next_read_data = 8'h00;
    case (address)
      `PORT_A_DATA_OFFSET: next_read_data = mix_read(port_a_data, a_sync, port_a_oe);
      `PORT_A_DIRECTION_OFFSET: next_read_data = port_a_direction;
      `PORT_B_DATA_OFFSET: next_read_data = mix_read(port_b_data, b_sync, port_b_oe);
      `PORT_B_DIRECTION_OFFSET: next_read_data = port_b_direction;
      `PORT_C_DATA_OFFSET: next_read_data = {`PORT_C_UNUSED_READ, c_read_mix[PORT_C_PINS-1:0]};
      `PORT_C_DIRECTION_OFFSET: next_read_data = {`PORT_C_UNUSED_READ, port_c_direction};
      `EXT_IRQ_ENABLE_OFFSET: next_read_data = ext_irq_enable_reg;
      `MISC_CONTROL_OFFSET: next_read_data = {`MISC_RESERVED_READ, low_voltage_detect_disable,
          osc_select_12mhz, usb_tx_enable_out, clock_out_enable};
      default: next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= 8'h00;
    end else if (clock_enable && read_strobe) begin
      read_data <= next_read_data;
    end
  end

  sequence misc_set_seq;
    clock_enable && write_strobe && address == `MISC_CONTROL_OFFSET && write_data[3];
  endsequence

  a_lvd_sticky: assert property (@(posedge clock) disable iff (reset)
    misc_set_seq |=> low_voltage_detect_disable [*3])
    else $error("detector disable bit not sticky");
  a_osc_sticky: assert property (@(posedge clock) disable iff (reset)
    $rose(osc_select_12mhz) |=> osc_select_12mhz [*4])
    else $error("oscillator select cleared by software");
  a_misc_upper: assert property (@(posedge clock) disable iff (reset)
    clock_enable && read_strobe && address == `MISC_CONTROL_OFFSET |=> read_data[7:4] == 4'hf)
    else $error("misc upper bits not set");
  a_portc_upper: assert property (@(posedge clock) disable iff (reset)
    clock_enable && read_strobe && address == `PORT_C_DIRECTION_OFFSET |=> read_data[7:3] == 5'h1f)
    else $error("port C upper bits not one");
  a_write_latch: assert property (@(posedge clock) disable iff (reset)
    clock_enable && write_strobe && address == `PORT_B_DATA_OFFSET |=> port_b_out == $past(write_data))
    else $error("port B latch not updated");
  a_clkout_drive: assert property (@(posedge clock) disable iff (reset)
    clock_out_enable |-> port_a_oe[0] && port_a_out[0] == cpu_clock_level)
    else $error("clock out not driven");
  a_compare_drive: assert property (@(posedge clock) disable iff (reset)
    compare_out_1_enable && !port_a_direction[6] |-> port_a_oe[6] && port_a_out[6] == timer_compare_out_1)
    else $error("compare output not forced");
  a_input_read: assert property (@(posedge clock) disable iff (reset)
    clock_enable && read_strobe && address == `PORT_B_DATA_OFFSET && port_b_oe == 8'h00
      |=> read_data == $past(b_sync))
    else $error("input read not live level");
  a_output_noirq: assert property (@(posedge clock) disable iff (reset)
    port_b_oe[5] |-> !ext_irq_line[5])
    else $error("output pin raised interrupt");
  a_dir_reset: assert property (@(posedge clock)
    reset |=> port_a_direction == 8'h00 && port_b_direction == 8'h00)
    else $error("direction not reset to input");

  // Edge cases that tests reach only briefly: one rising and one falling line
  sequence a4_rise_seq;
    clock_enable && sync_state == io_ports_pkg::SYNC_READY && a_sync[4] && !a_prev[4];
  endsequence
  sequence a4_armed_seq;
    !port_a_oe[4] && ext_irq_enable_reg[0];
  endsequence
  sequence b6_fall_seq;
    clock_enable && sync_state == io_ports_pkg::SYNC_READY && !b_sync[6] && b_prev[6];
  endsequence
  sequence b6_armed_seq;
    !port_b_oe[6] && ext_irq_enable_reg[6];
  endsequence

  a_irq_rise: assert property (@(posedge clock) disable iff (reset)
    a4_rise_seq and a4_armed_seq |=> ext_irq_vector[0])
    else $error("rising line one missed");
  a_irq_fall: assert property (@(posedge clock) disable iff (reset)
    b6_fall_seq and b6_armed_seq |=> ext_irq_vector[1])
    else $error("falling line seven missed");
  a_porta_noirq: assert property (@(posedge clock) disable iff (reset)
    port_a_oe[4] |-> !ext_irq_line[0])
    else $error("port A output pin raised interrupt");
  a_analog_onehot: assert property (@(posedge clock) disable iff (reset)
    converter_enable |-> $onehot(port_b_analog_select) && port_b_analog_select[converter_channel_select])
    else $error("analog select not one-hot on channel");
  a_analog_off: assert property (@(posedge clock) disable iff (reset)
    !converter_enable |-> port_b_analog_select == 8'h00)
    else $error("analog select active while converter off");
  a_i2c_drive: assert property (@(posedge clock) disable iff (reset)
    i2c_enable |-> port_a_oe[1] == !i2c_sda_out && port_a_oe[2] == !i2c_scl_out && port_a_out[2:1] == 2'b00)
    else $error("open-drain pins not following bus");
  a_pullup_mask: assert property (@(posedge clock) disable iff (reset)
    (port_a_pullup & port_a_oe) == 8'h00 && port_a_pullup[2:1] == 2'b00)
    else $error("pull-up on driven or open-drain pin");
  a_serial_drive: assert property (@(posedge clock) disable iff (reset)
    serial_enable |-> port_c_oe[1] && port_c_out[1] == serial_transmit_out)
    else $error("serial output not forced");
  a_usb_drive: assert property (@(posedge clock) disable iff (reset)
    usb_tx_enable_out |-> port_c_oe[2] && port_c_out[2] == usb_transmitting)
    else $error("usb enable not on pin");
  a_timer_external_clock_gate: assert property (@(posedge clock) disable iff (reset)
    !(timer_clock_ctl_hi && timer_clock_ctl_lo) |-> !timer_external_clock)
    else $error("external clock passed while not selected");
  a_compare2_drive: assert property (@(posedge clock) disable iff (reset)
    compare_out_2_enable |-> port_a_oe[7] && port_a_out[7] == timer_compare_out_2)
    else $error("second compare output not forced");
  a_state_freeze: assert property (@(posedge clock) disable iff (reset)
    !clock_enable |=> $stable(port_a_data) && $stable(port_a_direction) && $stable(sync_state))
    else $error("state moved while clock enable low");
  a_misc_reset: assert property (@(posedge clock)
    reset |=> !low_voltage_detect_disable && !osc_select_12mhz)
    else $error("sticky misc bits survived reset");

endmodule // io_ports_with_alt_functions
`default_nettype wire

// [inc/io_ports_regs.svh]
`ifndef IO_PORTS_REGS_SVH
`define IO_PORTS_REGS_SVH
`define PORT_A_DATA_OFFSET 4'h0
`define PORT_A_DIRECTION_OFFSET 4'h1
`define PORT_B_DATA_OFFSET 4'h2
`define PORT_B_DIRECTION_OFFSET 4'h3
`define PORT_C_DATA_OFFSET 4'h4
`define PORT_C_DIRECTION_OFFSET 4'h5
`define EXT_IRQ_ENABLE_OFFSET 4'h8
`define MISC_CONTROL_OFFSET 4'h9
`define PORT_RESET_VALUE 8'h00
`define PORT_C_UNUSED_READ 5'h1f
`define MISC_RESET_VALUE 8'hf0
`define MISC_RESERVED_READ 4'hf
`define MISC_CLOCK_OUT_BIT 0
`define MISC_USB_OE_BIT 1
`define MISC_OSC_SELECT_BIT 2
`define MISC_LVD_DISABLE_BIT 3
`define PORT_C_WIDTH 3
`endif

// [inc/io_ports_pkg.sv]
package io_ports_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [1:0] {
    SYNC_EMPTY = 2'b00,
    SYNC_FIRST = 2'b01,
    SYNC_SECOND = 2'b11,
    SYNC_READY = 2'b10
  } sync_state_type;
endpackage

// [tb/pin_world.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input wire logic clock,
  input wire logic drive,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] a_pullup,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  input wire logic [2:0] c_out,
  input wire logic [2:0] c_oe,
  input wire logic [2:0] c_pullup,
  input wire logic [2:0] ext_c,
  output logic [7:0] a_level,
  output logic [7:0] b_level,
  output logic [2:0] c_level
);
  // Released lines without pull-up wander, so a stale level is never read back
  logic [7:0] wander = 8'h55;
  always @(posedge clock) begin
    wander <= ~wander;
  end
  function automatic logic [7:0] resolve(input logic [7:0] o, input logic [7:0] oe, input logic [7:0] pu,
                                         input logic [7:0] ext, input logic drv, input logic [7:0] w);
    resolve = (oe & o) | (~oe & (drv ? ext : (pu | (~pu & w))));
  endfunction
  assign a_level = resolve(a_out, a_oe, a_pullup, ext_a, drive, wander);
  assign b_level = resolve(b_out, b_oe, 8'h00, ext_b, drive, wander);
  assign c_level = 3'(resolve({5'h00, c_out}, {5'h00, c_oe}, {5'h00, c_pullup}, {5'h00, ext_c}, drive, wander));
endmodule // pin_world
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, reset = 1'b1, clock_enable = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0, drive = 1'b0;
  logic [3:0] address = 4'h0, ext_irq_vector;
  logic [7:0] write_data = 8'h00, read_data, port_a_in, port_a_out, port_a_oe, port_a_pullup;
  logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_analog_select;
  logic [2:0] port_c_in, port_c_out, port_c_oe, port_c_pullup, converter_channel_select = 3'h0;
  logic cpu_clock_level = 1'b0, i2c_enable = 1'b0, i2c_sda_out = 1'b1, i2c_scl_out = 1'b1, i2c_sda_in, i2c_scl_in;
  logic timer_clock_ctl_hi = 1'b0, timer_clock_ctl_lo = 1'b0, timer_external_clock, timer_capture_in_1;
  logic timer_capture_in_2, timer_compare_out_1 = 1'b0, timer_compare_out_2 = 1'b0, compare_out_1_enable = 1'b0;
  logic compare_out_2_enable = 1'b0, serial_enable = 1'b0, serial_transmit_out = 1'b0, serial_receive_in;
  logic usb_transmitting = 1'b0, converter_enable = 1'b0, low_voltage_detect_disable, osc_select_12mhz;
  logic [7:0] ext_a = 8'hff, ext_b = 8'h00, v, da, dd, db, ddb;
  logic [2:0] ext_c = 3'h0, dc, ddc;
  logic [3:0] reg_addr [5] = '{4'h1, 4'h3, 4'h5, 4'h9, 4'h6};
  logic [7:0] reg_reset [5] = '{8'h00, 8'h00, 8'hf8, 8'hf0, 8'h00};
  integer seed = 32'h755f, mismatches = 0, total_checks = 0, irq_a = 0, irq_b = 0, irq_start = 0;

  io_ports_with_alt_functions dut (.*);
  pin_world pins (.clock(clock), .drive(drive), .a_out(port_a_out), .a_oe(port_a_oe), .a_pullup(port_a_pullup),
    .b_out(port_b_out), .b_oe(port_b_oe), .ext_a(ext_a), .ext_b(ext_b), .c_out(port_c_out), .c_oe(port_c_oe),
    .c_pullup(port_c_pullup), .ext_c(ext_c), .a_level(port_a_in), .b_level(port_b_in), .c_level(port_c_in));

  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (ext_irq_vector[0] === 1'b1) irq_a <= irq_a + 1;
    if (ext_irq_vector[1] === 1'b1) irq_b <= irq_b + 1;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(posedge clock);
    v = read_data;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_mix(input logic [7:0] latch, input logic [7:0] dir, input logic [7:0] pin);
    exp_mix = (latch & dir) | (pin & ~dir);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    // Pins take two edges to reach the synchroniser's output
    repeat (2) @(posedge clock);
    rd(4'h0);
    chk("pa_pullup_read", 8'hff, v | 8'h06);
    chk("pa_pullup", 8'hf9, port_a_pullup);
    chk("pb_oe", 8'h00, port_b_oe);
    chk("pc_pullup", 8'h07, {5'h00, port_c_pullup});
    rd(4'h4);
    chk("pc_read", 8'hff, v);
    foreach (reg_addr[i]) begin
      rd(reg_addr[i]);
      chk("reg_reset", reg_reset[i], v);
    end
    drive <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      da = 8'($random(seed));
      dd = 8'($random(seed)) & 8'hf9;
      db = 8'($random(seed));
      ddb = 8'($random(seed));
      dc = 3'($random(seed));
      ddc = 3'($random(seed));
      wr(4'h0, da);
      wr(4'h1, dd);
      wr(4'h2, db);
      wr(4'h3, ddb);
      wr(4'h4, {5'h00, dc});
      wr(4'h5, {5'h00, ddc});
      ext_a <= 8'($random(seed));
      ext_b <= 8'($random(seed));
      ext_c <= 3'($random(seed));
      repeat (3) @(posedge clock);
      rd(4'h0);
      chk("pa_read", exp_mix(da, dd, ext_a), v);
      rd(4'h2);
      chk("pb_read", exp_mix(db, ddb, ext_b), v);
      rd(4'h4);
      chk("pc_read", {5'h1f, 3'(exp_mix({5'h00, dc}, {5'h00, ddc}, {5'h00, ext_c}))}, v);
      rd(4'h5);
      chk("pc_dir", {5'h1f, ddc}, v);
      rd(4'h1);
      chk("pa_dir", dd, v);
      chk("pa_oe", dd, port_a_oe);
      chk("pb_oe", ddb, port_b_oe);
      chk("pa_out", da & dd, port_a_out & dd);
      chk("pb_out", db & ddb, port_b_out & ddb);
    end
    clock_enable <= 1'b0;
    wr(4'h1, ~dd);
    clock_enable <= 1'b1;
    rd(4'h1);
    chk("freeze", dd, v);
    $display("test gpio done");
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    ext_a <= 8'hc0;
    ext_b <= 8'hc0;
    wr(4'h8, 8'hff);
    repeat (6) @(posedge clock);
    for (int k = 0; k < 8; k++) begin
      irq_start = k < 4 ? irq_a : irq_b;
      for (int t = 0; t < 2; t++) begin
        if (k < 4) ext_a[k + 4] <= ~ext_a[k + 4];
        else ext_b[k] <= ~ext_b[k];
        repeat (6) @(posedge clock);
      end
      chk("irq_count", 8'h01, 8'((k < 4 ? irq_a : irq_b) - irq_start));
    end
    irq_start = irq_a;
    wr(4'h1, 8'h10);
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h8, 8'h00);
    ext_a[4] <= 1'b1;
    repeat (6) @(posedge clock);
    chk("irq_quiet", 8'h00, 8'(irq_a - irq_start));
    $display("test interrupt done");
    wr(4'h9, 8'h0f);
    rd(4'h9);
    chk("misc_set", 8'hff, v);
    wr(4'h9, 8'h00);
    rd(4'h9);
    chk("misc_sticky", 8'hfc, v);
    chk("lvd_osc", 8'h03, {6'h00, low_voltage_detect_disable, osc_select_12mhz});
    wr(4'h9, 8'h03);
    cpu_clock_level <= 1'b1;
    usb_transmitting <= 1'b1;
    repeat (2) @(posedge clock);
    chk("clk_usb", 8'h0f, {4'h0, port_a_oe[0], port_a_out[0], port_c_oe[2], port_c_out[2]});
    cpu_clock_level <= 1'b0;
    usb_transmitting <= 1'b0;
    repeat (2) @(posedge clock);
    chk("clk_usb", 8'h0a, {4'h0, port_a_oe[0], port_a_out[0], port_c_oe[2], port_c_out[2]});
    wr(4'h9, 8'h00);
    // Only reset may clear the sticky bits; it also returns every pin to input
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    rd(4'h9);
    chk("misc_reset", 8'hf0, v);
    rd(4'h5);
    chk("pc_dir_reset", 8'hf8, v);
    $display("test misc done");
    // Interrupts are off and directions are input before any alternate use
    compare_out_1_enable <= 1'b1;
    timer_compare_out_1 <= 1'b1;
    compare_out_2_enable <= 1'b1;
    i2c_enable <= 1'b1;
    i2c_sda_out <= 1'b0;
    serial_enable <= 1'b1;
    serial_transmit_out <= 1'b1;
    timer_clock_ctl_hi <= 1'b1;
    timer_clock_ctl_lo <= 1'b1;
    ext_a <= 8'h1c;
    ext_c <= 3'h1;
    repeat (3) @(posedge clock);
    chk("alt_oe", 8'hc2, port_a_oe);
    chk("alt_out", 8'h40, port_a_out & port_a_oe);
    chk("pc_alt", 8'h03, {6'h00, port_c_oe[1], port_c_out[1]});
    chk("alt_in", 8'h35, {2'h0, timer_external_clock, timer_capture_in_1, timer_capture_in_2,
                          serial_receive_in, i2c_sda_in, i2c_scl_in});
    rd(4'h0);
    chk("pa_live", 8'h1c, v);
    timer_clock_ctl_lo <= 1'b0;
    repeat (3) @(posedge clock);
    chk("ext_clock_off", 8'h00, {7'h00, timer_external_clock});
    $display("test alternate done");
    converter_enable <= 1'b1;
    for (int ch = 0; ch < 8; ch++) begin
      converter_channel_select <= 3'(ch);
      repeat (2) @(posedge clock);
      chk("analog", 8'h01 << ch, port_b_analog_select);
    end
    converter_enable <= 1'b0;
    repeat (2) @(posedge clock);
    chk("analog_off", 8'h00, port_b_analog_select);
    $display("test analog done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
